// ==== include/bsc_pkg.sv ====
package bsc_pkg;
   localparam int CNT_W = 6;
   localparam logic [CNT_W-1:0] UP_CNT_INIT = 6'h14;   // 20
   localparam logic [CNT_W-1:0] DN_CNT_INIT = 6'h28;   // 40
   localparam logic [CNT_W-1:0] UP_CNT_LIMIT = 6'h14;
   localparam logic [CNT_W-1:0] DN_CNT_LIMIT = 6'h28;
   localparam logic [31:0] SWITCH_RATE = 32'h0000_2580;   // 9600 bit/s
   localparam logic [31:0] CORE_RATE_MIN = 32'h0000_0960; // 2400 bit/s
   localparam logic [31:0] OUT_RATE_MIN = 32'h0000_7D00;  // 32000 Hz
   // gains are unsigned q8.8, energies unsigned integers
   localparam int GW = 16;
   localparam int FRAC = 8;
   localparam logic [GW-1:0] TILT_FRIC = 16'h0500;   // 5.0
   localparam logic [GW-1:0] GAIN_HALF = 16'h0080;   // 0.5
   localparam logic [GW-1:0] GAIN_ONE = 16'h0100;    // 1.0
   localparam logic [GW-1:0] GAIN_TWO = 16'h0200;    // 2.0
   localparam logic [GW-1:0] TILT_MAX = 16'h0800;    // 8.0
   localparam logic [GW-1:0] GAIN_TENTH = 16'h001A;  // 0.1
   localparam logic [GW-1:0] GAIN_FIFTH = 16'h0033;  // 0.2
   localparam logic [GW-1:0] GAIN_4FIFTH = 16'h00CD; // 0.8
   localparam logic [GW-1:0] GAIN_QUART = 16'h0040;  // 0.25
   localparam logic [GW-1:0] GAIN_20TH = 16'h000D;   // 0.05
   typedef enum logic [1:0] {
      BSC_BW_NB = 2'b00,
      BSC_BW_WB = 2'b01,
      BSC_BW_SWB = 2'b10,
      BSC_BW_FB = 2'b11
   } bsc_bw_e;
   typedef enum logic [1:0] {
      BSC_MODE_NONE = 2'b00,
      BSC_MODE_TD = 2'b01,
      BSC_MODE_FD = 2'b10,
      BSC_MODE_MDCT = 2'b11
   } bsc_mode_e;
   typedef enum logic [1:0] {
      BSC_CODER_OTHER = 2'b00,
      BSC_CODER_AUDIO = 2'b01,
      BSC_CODER_INACTIVE = 2'b10
   } bsc_coder_e;
   typedef enum logic [1:0] {
      BSC_CORE_CELP = 2'b00,
      BSC_CORE_MDCT = 2'b01,
      BSC_CORE_OTHER = 2'b10
   } bsc_core_e;
   typedef struct packed {
      bsc_bw_e bandwidth;
      logic [31:0] total_rate;
      logic [31:0] core_rate;
      logic [31:0] output_sample_rate;
      bsc_coder_e coder_type;
      bsc_core_e core;
      logic ppp_mode;
   } bsc_frame_s;
   typedef struct packed {
      logic [GW-1:0] tilt;
      logic low_corr_low;
      logic [GW-1:0] lowband_ratio;
      logic [GW-1:0] prior_ratio;
      logic [31:0] band_energy;
      logic [31:0] upper_lowband_energy;
      logic [31:0] initial_energy;
   } bsc_gain_in_s;
endpackage

// ==== src/bsc_gain.sv ====
`timescale 1ns/100ps
module bsc_gain
   import bsc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic start,
   input wire bsc_pkg::bsc_gain_in_s gin,
   input wire logic [bsc_pkg::CNT_W-1:0] down_cnt,
   input wire logic [bsc_pkg::CNT_W-1:0] up_cnt,
   input wire logic fric_prev,
   output logic fric_out,
   output logic [bsc_pkg::GW-1:0] gain_out,
   output logic done
);
   function automatic logic [GW-1:0] qmul(input logic [GW-1:0] a, input logic [GW-1:0] b);
      logic [2*GW-1:0] p;
      p = a * b;
      qmul = (p[2*GW-1:GW+FRAC] != '0) ? '1 : p[GW+FRAC-1:FRAC];
   endfunction
   // energy quotient in q8.8, saturated; divider kept combinational for one-cycle latency
   function automatic logic [GW-1:0] qdiv(input logic [31:0] n, input logic [31:0] d);
      logic [47:0] q;
      q = (d == '0) ? '1 : ({n, 16'h0000} >> FRAC) / {16'h0000, d};
      qdiv = (q[47:GW] != '0) ? '1 : q[GW-1:0];
   endfunction
   logic fric_reg, fric_next;
   logic [GW-1:0] gain_reg, gain_next;
   logic done_reg, done_next;
   logic [GW-1:0] g, ratio_g, tmp;
   logic [47:0] lim;
   always_comb begin
      fric_next = fric_reg;
      gain_next = gain_reg;
      done_next = 1'b0;
      g = '0;
      ratio_g = '0;
      tmp = '0;
      lim = '0;
      if (start) begin
         fric_next = !fric_prev && gin.tilt > TILT_FRIC && gin.low_corr_low;
         if (fric_next) begin
            g = (gin.tilt < GAIN_HALF) ? GAIN_HALF : (gin.tilt > GAIN_ONE) ? GAIN_ONE : gin.tilt;
         end else begin
            g = ((gin.tilt > TILT_MAX) ? TILT_MAX : gin.tilt) << 2;
         end
         ratio_g = qdiv(gin.upper_lowband_energy, gin.initial_energy);
         lim = {16'h0000, gin.upper_lowband_energy} * {32'h0000_0000, GAIN_20TH};
         if (gin.band_energy > gin.upper_lowband_energy) begin
            g = qmul(GAIN_HALF, ratio_g);
         end else if ({8'h00, gin.band_energy, 8'h00} < lim) begin
            g = qmul(GAIN_QUART, ratio_g);
         end
         if (fric_next && fric_prev && g > gin.prior_ratio) begin
            g = qmul(GAIN_FIFTH, g) + qmul(GAIN_4FIFTH, gin.prior_ratio);
         end else if (gin.lowband_ratio >= GAIN_HALF && gin.lowband_ratio <= GAIN_TWO
                      && fric_next == fric_prev) begin
            g = (g >> 1) + (gin.prior_ratio >> 1);
         end else if (!fric_next && fric_prev) begin
            tmp = qmul(GAIN_TENTH, g);
            g = qmul(GAIN_ONE - ((tmp > GAIN_ONE) ? GAIN_ONE : tmp), g) + qmul(tmp, gin.prior_ratio);
         end else begin
            g = (g >> 1) + (((g < gin.prior_ratio) ? g : gin.prior_ratio) >> 1);
         end
         g = GW'(({16'h0000, g} * (32'(DN_CNT_LIMIT) - 32'(down_cnt))) / 32'(DN_CNT_LIMIT));
         if (up_cnt != '0) begin
            g = GW'(({16'h0000, g} * 32'(up_cnt)) / 32'(UP_CNT_LIMIT));
         end
         gain_next = g;
         done_next = 1'b1;
      end
   end
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         fric_reg <= 1'b0;
         gain_reg <= '0;
         done_reg <= 1'b0;
      end else begin
         fric_reg <= fric_next;
         gain_reg <= gain_next;
         done_reg <= done_next;
      end
   end
   assign fric_out = fric_reg;
   assign gain_out = gain_reg;
   assign done = done_reg;
endmodule

// ==== src/bsc_top.sv ====
`timescale 1ns/100ps
module bsc_top
   import bsc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic frame_valid,
   input wire bsc_pkg::bsc_frame_s frame,
   input wire bsc_pkg::bsc_gain_in_s gain_in,
   output logic [bsc_pkg::CNT_W-1:0] upward_switch_counter,
   output logic [bsc_pkg::CNT_W-1:0] downward_switch_counter,
   output logic up_switch_active,
   output logic down_switch_active,
   output bsc_pkg::bsc_mode_e extension_mode,
   output logic mode_valid,
   output logic [bsc_pkg::GW-1:0] high_band_global_gain,
   output logic gain_valid,
   output logic fricative
);
   import bsc_pkg::*;
   logic rs1_reg, rs2_reg;
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rs1_reg <= 1'b0;
         rs2_reg <= 1'b0;
      end else begin
         rs1_reg <= 1'b1;
         rs2_reg <= rs1_reg;
      end
   end
   logic rst_n;
   assign rst_n = rs2_reg;

   logic [CNT_W-1:0] up_reg, up_next, dn_reg, dn_next;
   bsc_bw_e bw_prev_reg, bw_prev_next;
   logic [31:0] rate_prev_reg, rate_prev_next;
   bsc_mode_e mode_reg, mode_next;
   logic mv_reg, mv_next;
   logic gstart_reg, gstart_next;
   bsc_gain_in_s gin_reg, gin_next;
   logic dropped, rose;
   logic [CNT_W-1:0] up_mid;
   logic [CNT_W-1:0] dn_from_up;

   always_comb begin
      up_next = up_reg;
      dn_next = dn_reg;
      bw_prev_next = bw_prev_reg;
      rate_prev_next = rate_prev_reg;
      mode_next = mode_reg;
      mv_next = 1'b0;
      gstart_next = 1'b0;
      gin_next = gin_reg;
      up_mid = up_reg;
      dn_from_up = dn_reg;
      dropped = frame.bandwidth < bw_prev_reg;
      rose = frame.bandwidth > bw_prev_reg;
      if (frame_valid) begin
         // upward counter chain
         if (up_reg >= UP_CNT_LIMIT) begin
            up_mid = '0;
         end else if (frame.bandwidth == BSC_BW_SWB && frame.total_rate > SWITCH_RATE
                      && bw_prev_reg == BSC_BW_WB && rate_prev_reg <= SWITCH_RATE) begin
            up_mid = up_reg + 6'h01;
         end else if (up_reg != '0) begin
            if (dropped) begin
               up_mid = '0;
               dn_from_up = CNT_W'(2 * (32'(UP_CNT_LIMIT) - 32'(up_reg)) - 1);
            end else if (frame.bandwidth == BSC_BW_SWB) begin
               up_mid = up_reg + 6'h01;
               dn_from_up = '0;
            end else begin
               up_mid = '0;
               dn_from_up = '0;
            end
         end
         // downward counter chain, seen after the upward update
         up_next = up_mid;
         dn_next = dn_from_up;
         if (dn_from_up >= DN_CNT_LIMIT) begin
            dn_next = '0;
         end else if (frame.total_rate <= SWITCH_RATE && rate_prev_reg > SWITCH_RATE
                      && dropped && frame.bandwidth == BSC_BW_WB) begin
            dn_next = dn_from_up + 6'h01;
         end else if (dn_from_up != '0) begin
            if (rose) begin
               dn_next = '0;
               up_next = CNT_W'((32'(DN_CNT_LIMIT) - 32'(dn_from_up)) / 2);
            end else if (frame.bandwidth == BSC_BW_WB) begin
               dn_next = dn_from_up + 6'h01;
               up_next = '0;
            end else begin
               dn_next = '0;
               up_next = '0;
            end
         end
         bw_prev_next = frame.bandwidth;
         rate_prev_next = frame.total_rate;
         // mode selection uses this frame's downward counter
         if (frame.core == BSC_CORE_MDCT) begin
            mode_next = BSC_MODE_MDCT;
         end else if (frame.coder_type != BSC_CODER_AUDIO && frame.coder_type != BSC_CODER_INACTIVE
                      && frame.core_rate > CORE_RATE_MIN && frame.core == BSC_CORE_CELP
                      && frame.output_sample_rate >= OUT_RATE_MIN && frame.bandwidth > BSC_BW_NB
                      && dn_next != '0 && !frame.ppp_mode) begin
            mode_next = BSC_MODE_TD;
         end else if (frame.core == BSC_CORE_CELP && frame.output_sample_rate >= OUT_RATE_MIN
                      && frame.bandwidth > BSC_BW_NB && dn_next != '0 && !frame.ppp_mode) begin
            mode_next = BSC_MODE_FD;
         end else begin
            mode_next = BSC_MODE_NONE;
         end
         mv_next = 1'b1;
         // gain stage runs next cycle only in time-domain mode
         gstart_next = (mode_next == BSC_MODE_TD);
         gin_next = gain_in;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         up_reg <= UP_CNT_INIT;
         dn_reg <= DN_CNT_INIT;
         bw_prev_reg <= BSC_BW_NB;
         rate_prev_reg <= '0;
         mode_reg <= BSC_MODE_NONE;
         mv_reg <= 1'b0;
         gstart_reg <= 1'b0;
         gin_reg <= '0;
      end else begin
         up_reg <= up_next;
         dn_reg <= dn_next;
         bw_prev_reg <= bw_prev_next;
         rate_prev_reg <= rate_prev_next;
         mode_reg <= mode_next;
         mv_reg <= mv_next;
         gstart_reg <= gstart_next;
         gin_reg <= gin_next;
      end
   end

   logic fric_q;
   bsc_gain u_gain (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .start(gstart_reg),
      .gin(gin_reg),
      .down_cnt(dn_reg),
      .up_cnt(up_reg),
      .fric_prev(fric_q),
      .fric_out(fric_q),
      .gain_out(high_band_global_gain),
      .done(gain_valid)
   );

   assign upward_switch_counter = up_reg;
   assign downward_switch_counter = dn_reg;
   assign up_switch_active = (up_reg != '0);
   assign down_switch_active = (dn_reg != '0);
   assign extension_mode = mode_reg;
   assign mode_valid = mv_reg;
   assign fricative = fric_q;
endmodule

// ==== testbench/bsc_top_properties.sv ====
`timescale 1ns/100ps
module bsc_top_properties
   import bsc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic frame_valid,
   input wire bsc_pkg::bsc_frame_s frame,
   input wire logic [bsc_pkg::CNT_W-1:0] upward_switch_counter,
   input wire logic [bsc_pkg::CNT_W-1:0] downward_switch_counter,
   input wire logic up_switch_active,
   input wire logic down_switch_active,
   input wire bsc_pkg::bsc_mode_e extension_mode,
   input wire logic mode_valid,
   input wire logic gain_valid
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);
   logic base_ok;
   logic td_ok;
   assign base_ok = frame.core == BSC_CORE_CELP && frame.output_sample_rate >= OUT_RATE_MIN
      && frame.bandwidth != BSC_BW_NB && !frame.ppp_mode;
   assign td_ok = frame.coder_type != BSC_CODER_AUDIO && frame.coder_type != BSC_CODER_INACTIVE
      && frame.core_rate > CORE_RATE_MIN;
   chk_mode_pulse: assert property (frame_valid |=> mode_valid)
      else $error("no mode strobe");
   chk_mode_cause: assert property (mode_valid |-> $past(frame_valid))
      else $error("stray mode strobe");
   chk_up_flag: assert property (up_switch_active == (upward_switch_counter != '0))
      else $error("up flag wrong");
   chk_dn_flag: assert property (down_switch_active == (downward_switch_counter != '0))
      else $error("down flag wrong");
   chk_td_pick:
      assert property (frame_valid && base_ok && td_ok
         |=> !down_switch_active || extension_mode == BSC_MODE_TD)
      else $error("td mode missed");
   chk_fd_pick:
      assert property (frame_valid && base_ok && !td_ok
         |=> !down_switch_active || extension_mode == BSC_MODE_FD)
      else $error("fd mode missed");
   chk_pitch_none:
      assert property (frame_valid && frame.core != BSC_CORE_MDCT && frame.ppp_mode
         |=> extension_mode == BSC_MODE_NONE)
      else $error("pitch frame extended");
   chk_mdct_pick:
      assert property (frame_valid && frame.core == BSC_CORE_MDCT
         |=> !down_switch_active || extension_mode == BSC_MODE_MDCT)
      else $error("mdct mode missed");
   chk_gain_td: assert property (mode_valid && extension_mode == BSC_MODE_TD |=> gain_valid)
      else $error("no gain strobe");
   chk_gain_cause:
      assert property ($rose(gain_valid) |-> $past(mode_valid) && extension_mode == BSC_MODE_TD)
      else $error("stray gain strobe");
   chk_first_clear:
      assert property (frame_valid && upward_switch_counter >= UP_CNT_LIMIT && downward_switch_counter >= DN_CNT_LIMIT
         |=> upward_switch_counter == '0 && downward_switch_counter == '0)
      else $error("counters not cleared");
endmodule
bind bsc_top bsc_top_properties u_chk (.ref_clk(ref_clk), .resetn(resetn), .frame_valid(frame_valid), .frame(frame),
   .upward_switch_counter(upward_switch_counter), .downward_switch_counter(downward_switch_counter),
   .up_switch_active(up_switch_active), .down_switch_active(down_switch_active),
   .extension_mode(extension_mode), .mode_valid(mode_valid), .gain_valid(gain_valid));

// ==== testbench/bsc_core_model.sv ====
`timescale 1ns/100ps
module bsc_core_model
   import bsc_pkg::*;
(
   input wire logic ref_clk,
   output logic frame_valid,
   output bsc_pkg::bsc_frame_s frame,
   output bsc_pkg::bsc_gain_in_s gain_in
);
   initial begin
      frame_valid = 1'b0;
      frame = '0;
      gain_in = '0;
   end
   // two idle cycles at least, so extension_mode still holds when the gain strobe comes
   task automatic push(input int gap, input bsc_frame_s f, input bsc_gain_in_s g);
      repeat (gap + 1) @(posedge ref_clk);
      #1;
      frame_valid = 1'b1;
      frame = f;
      gain_in = g;
      @(posedge ref_clk);
      #1;
      frame_valid = 1'b0;
      // scrambled once taken, so a late sample cannot pass
      frame = bsc_frame_s'(~f);
      gain_in = bsc_gain_in_s'(~g);
   endtask
endmodule

// ==== testbench/test_bandwidth_switch_control.sv ====
`timescale 1ns/100ps
module test_bandwidth_switch_control;
   import bsc_pkg::*;
   localparam logic [31:0] HI = 32'h0000_3390;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic fv;
   bsc_frame_s fr;
   bsc_gain_in_s gi;
   logic [CNT_W-1:0] uc;
   logic [CNT_W-1:0] dc;
   logic ua;
   logic da;
   bsc_mode_e md;
   wire [1:0] vld;
   logic [GW-1:0] gn;
   logic fc;
   int err_total = 0;
   int tests_run = 0;
   logic [CNT_W-1:0] eu = 6'h14;
   logic [CNT_W-1:0] ed = 6'h28;
   bsc_bw_e pbw = BSC_BW_NB;
   logic [31:0] pr = '0;
   always #4 ref_clk = ~ref_clk;
   bsc_core_model u_core (.ref_clk(ref_clk), .frame_valid(fv), .frame(fr), .gain_in(gi));
   bsc_top u_dut (.ref_clk(ref_clk), .resetn(resetn), .frame_valid(fv), .frame(fr), .gain_in(gi),
      .upward_switch_counter(uc), .downward_switch_counter(dc), .up_switch_active(ua), .down_switch_active(da),
      .extension_mode(md), .mode_valid(vld[0]), .high_band_global_gain(gn), .gain_valid(vld[1]), .fricative(fc));
   task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         err_total++;
         $display("BAD %s expected %0h seen %0h", nm, e, s);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic wait_hi(input int k);
      for (int n = 0; vld[k] !== 1'b1; n++) begin
         if (n == 3) begin
            err_total++;
            close_out();
         end
         @(posedge ref_clk);
         #1;
      end
   endtask
   function automatic bsc_gain_in_s gin(logic [15:0] t, logic c, logic [15:0] l, logic [15:0] p, logic [31:0] b,
         logic [31:0] i);
      return '{t, c, l, p, b, 32'h3E8, i};
   endfunction
   task automatic send(input bsc_bw_e bw, input logic [31:0] rt, input bsc_coder_e cd = BSC_CODER_OTHER,
         input bsc_core_e co = BSC_CORE_CELP, input bsc_gain_in_s g = '{16'h0200, 1'b0, 16'h0100, 16'h1000,
         32'h64, 32'h3E8, 32'h3E8}, input logic pp = 1'b0);
      logic [CNT_W-1:0] u;
      logic [CNT_W-1:0] d;
      bsc_mode_e m;
      u = eu;
      d = ed;
      if (u >= 6'h14) u = '0;
      else if (bw == BSC_BW_SWB && rt > SWITCH_RATE && pbw == BSC_BW_WB && pr <= SWITCH_RATE) u = u + 6'h01;
      else if (u != '0) begin
         d = (bw < pbw) ? 6'h27 - {u[4:0], 1'b0} : '0;
         u = (bw >= pbw && bw == BSC_BW_SWB) ? u + 6'h01 : '0;
      end
      if (d >= 6'h28) d = '0;
      else if (rt <= SWITCH_RATE && pr > SWITCH_RATE && bw < pbw && bw == BSC_BW_WB) d = d + 6'h01;
      else if (d != '0) begin
         u = (bw > pbw) ? (6'h28 - d) >> 1 : '0;
         d = (bw <= pbw && bw == BSC_BW_WB) ? d + 6'h01 : '0;
      end
      m = BSC_MODE_NONE;
      if (co == BSC_CORE_MDCT) m = BSC_MODE_MDCT;
      else if (d != '0 && co == BSC_CORE_CELP && !pp) m = (cd == BSC_CODER_OTHER) ? BSC_MODE_TD : BSC_MODE_FD;
      eu = u;
      ed = d;
      pbw = bw;
      pr = rt;
      // odd counts get a slow source
      u_core.push(d[0] ? 6 : 2, '{bw, rt, 32'h2580, 32'h7D00, cd, co, pp}, g);
      wait_hi(0);
      check("up", uc, eu);
      check("down", dc, ed);
      check("flags", {ua, da}, {eu != '0, ed != '0});
      check("mode", md, m);
   endtask
   // seven lsb of slack either side for fixed-point rounding
   task automatic gchk(input logic [GW-1:0] e, input logic f);
      wait_hi(1);
      check("gain", gn + 16'h8 > e && gn < e + 16'h8, 1'b1);
      check("fric", fc, f);
   endtask
   initial begin
      repeat (2) @(posedge ref_clk);
      #1;
      resetn = 1'b1;
      repeat (3) @(posedge ref_clk);
      #1;
      check("init", {uc, dc, ua, da, vld}, {6'h14, 6'h28, 4'hC});
      $display("reset test done");
      send(BSC_BW_WB, SWITCH_RATE);
      repeat (19) send(BSC_BW_SWB, HI);
      $display("upward test done");
      send(BSC_BW_WB, SWITCH_RATE);
      gchk(16'h0B66, 1'b0);
      send(BSC_BW_WB, SWITCH_RATE, BSC_CODER_AUDIO);
      send(BSC_BW_WB, SWITCH_RATE, BSC_CODER_INACTIVE);
      send(BSC_BW_WB, SWITCH_RATE, BSC_CODER_OTHER, BSC_CORE_MDCT);
      send(BSC_BW_WB, SWITCH_RATE, BSC_CODER_OTHER, BSC_CORE_OTHER);
      $display("mode test done");
      send(BSC_BW_WB, SWITCH_RATE, BSC_CODER_OTHER, BSC_CORE_CELP,
         gin(16'h0200, 1'b0, 16'h0300, 16'h0100, 32'h7D0, 32'h3E8));
      gchk(16'h006A, 1'b0);
      send(BSC_BW_WB, SWITCH_RATE, BSC_CODER_OTHER, BSC_CORE_CELP,
         gin(16'h0200, 1'b0, 16'h0100, 16'h0080, 32'hA, 32'h1F4));
      gchk(16'h0066, 1'b0);
      send(BSC_BW_WB, SWITCH_RATE, BSC_CODER_OTHER, BSC_CORE_CELP,
         gin(16'h0600, 1'b1, 16'h0100, 16'h0100, 32'h64, 32'h3E8));
      gchk(16'h00C6, 1'b1);
      $display("gain test done");
      // pitch-period frame inside a down switch gets no extension
      send(BSC_BW_WB, SWITCH_RATE, BSC_CODER_OTHER, BSC_CORE_CELP,
         gin(16'h0200, 1'b0, 16'h0100, 16'h1000, 32'h64, 32'h3E8), 1'b1);
      $display("pitch mode test done");
      repeat (7) send(BSC_BW_SWB, HI);
      $display("rise test done");
      repeat (41) send(BSC_BW_WB, SWITCH_RATE);
      $display("down wrap test done");
      close_out();
   end
endmodule
